//--- bench/tb.sv
// tb: drives the pipeline over APB and a pixel source, checks each pixel
// against a model of the overlay mixing. assumes vio_pkg compiled first.
`timescale 1ns/1ps
module tb;
  import vio_pkg::*;
  logic i_core_clk = 0, i_rstn = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic i_frame_start = 0, go = 0, nl = 0, o_pready, o_pslverr, o_valid;
  logic o_field, o_line_active;
  logic i_pix_valid, i_line_start, i_blend_level_low, i_blend_level_high;
  logic [11:0] i_paddr = 0;
  logic [31:0] i_pwdata = 0, o_prdata;
  logic [28:0] px_in = 0;
  logic [23:0] i_pix, q[$];
  logic [7:0]  o_y, o_cb, o_cr;
  logic [2:0]  i_overlay_hue_pick;
  int          n_errors = 0, checks = 0, skip = 0;
  initial forever #2.5 i_core_clk = ~i_core_clk;
  vio_pix_src src (.i_core_clk, .i_go(go), .i_new_line(nl), .i_px(px_in),
    .o_px({i_overlay_hue_pick, i_blend_level_high, i_blend_level_low,
    i_pix}), .o_pix_valid(i_pix_valid), .o_line_start(i_line_start));
  vio_input_overlay_upscaler dut (.*);
  function automatic logic [23:0] bl(logic [23:0] a, b, int w);
    for (int i = 0; i < 24; i += 8)
      bl[i+:8] = 8'((a[i+:8] * w + b[i+:8] * (8 - w) + 4) >> 3);
  endfunction
  function automatic logic [23:0] col(logic [2:0] s, logic [23:0] p);
    return s != 0 ? VIO_PALETTE[s] : p;
  endfunction
  task automatic chk(string nm, logic [32:0] e, s);
    checks++;
    if (s !== e) n_errors++;
    if (s !== e) $display("mismatch %s expected %h seen %h", nm, e, s);
  endtask
  task automatic test_done;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, e, logic ee);
    int t = 0;
    @(posedge i_core_clk) {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
    @(posedge i_core_clk) i_penable <= 1;
    do @(posedge i_core_clk); while (o_pready !== 1'b1 && ++t < 50);
    {i_psel, i_penable} <= 2'b00;
    if (t == 50) n_errors++;
    if (t == 50) test_done;
    if (!w) chk("prdata", e, o_prdata);
    chk("pslverr", ee, o_pslverr);
  endtask
  always @(posedge i_core_clk)
    if (o_valid === 1'b1 && skip > 0) skip--;
    else if (o_valid === 1'b1 && q.size() > 0)
      chk("pixel", q.pop_front(), {o_y, o_cb, o_cr});
  // one line per mode; the last three pixels are sel 0 padding
  task automatic seg(logic [1:0] m, int n);
    logic [28:0] p[$];
    logic [23:0] a, c;
    logic [2:0]  s, sn, sp;
    apb(1, CTRL_ADDR, 32'(m) << CTRL_MIX_LSB, 0, 0);
    c = 24'($urandom);
    for (int k = 0; k < n + 3; k++) begin
      if (k % 3 == 0 || m != MIX_INT) s = k < n ? 3'($urandom) : 3'h0;
      p.push_back({s, 2'($urandom), 8'($urandom), c[15:0]});
    end
    for (int k = 0; k < n; k++) begin
      s = p[k][28:26];
      sn = p[k+1][28:26];
      sp = k > 0 ? p[k-1][28:26] : 3'h0;
      a = col(s, p[k][23:0]);
      q.push_back(m == MIX_OFF ? p[k][23:0] : m == MIX_HARD ? a
        : m == MIX_EXT ? bl(a, p[k][23:0], 7 * p[k][25] + p[k][24])
        : sn != s ? bl(col(sn, p[k][23:0]), a, 1)
        : sp != s ? bl(a, col(sp, p[k][23:0]), 7) : a);
    end
    @(posedge i_core_clk) nl <= 1;
    @(posedge i_core_clk) nl <= 0;
    // first three outputs of a line belong to the pipeline's older pixels
    skip = 3;
    foreach (p[k]) begin
      {go, px_in} <= {1'b1, p[k]};
      @(posedge i_core_clk) go <= 0;
      @(posedge i_core_clk);
    end
  endtask
  initial begin
    void'($urandom(91));
    repeat (12) @(posedge i_core_clk);
    i_rstn <= 1;
    apb(1, CTRL_ADDR, 32'hFFFF_FFFF, 0, 0);
    apb(0, CTRL_ADDR, 0, CTRL_MASK, 0);
    apb(1, STATUS_ADDR, 0, 0, 0);
    apb(0, 12'h008, 0, 0, 1);
    for (int i = 0; i < 4; i++) seg(2'(i), 12 + 6 * i);
    seg(MIX_OFF, 3);
    repeat (20) @(posedge i_core_clk);
    chk("left", 0, 33'(q.size()));
    // five line starts, no frame start: line 5 of field 0, active
    chk("field", 0, o_field);
    chk("active", 1, o_line_active);
    test_done;
  end
endmodule

//--- bench/vio_assertions.sv
// vio_chk: bus handshake and output hold checks on the pipeline top.
// assumes: bound into vio_input_overlay_upscaler; one clock domain.
`timescale 1ns/1ps
module vio_chk (
  input wire logic        i_core_clk, i_rstn,           // clock, reset
  input wire logic        i_psel, i_penable, i_pwrite,  // bus request
  input wire logic [11:0] i_paddr,                      // bus address
  input wire logic        o_pready, o_pslverr, o_valid, // answers
  input wire logic [31:0] o_prdata,                     // read data
  input wire logic [7:0]  o_y, o_cb, o_cr               // pixel out
);
  import vio_pkg::*;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  wire rd = o_pready && !i_pwrite;
  sequence s_wait; i_psel && i_penable && !o_pready; endsequence
  property p_wait; s_wait |=> o_pready; endproperty
  a_wait: assert property (p_wait) else $error("ready late");
  property p_one; o_pready |=> !o_pready; endproperty
  a_one: assert property (p_one) else $error("ready too long");
  property p_req; o_pready |-> i_psel && i_penable; endproperty
  a_req: assert property (p_req) else $error("ready unasked");
  property p_err; o_pready && i_paddr > STATUS_ADDR |-> o_pslverr; endproperty
  a_err: assert property (p_err) else $error("no error");
  property p_ok; o_pready && i_paddr == CTRL_ADDR |-> !o_pslverr; endproperty
  a_ok: assert property (p_ok) else $error("false error");
  property p_zero; rd && o_pslverr |-> o_prdata == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("error data");
  property p_mask; rd && i_paddr == CTRL_ADDR |-> !(o_prdata & ~CTRL_MASK);
  endproperty
  a_mask: assert property (p_mask) else $error("spare bits set");
  property p_hold; !o_valid |-> $stable({o_y, o_cb, o_cr}); endproperty
  a_hold: assert property (p_hold) else $error("pixel moved");
endmodule
bind vio_input_overlay_upscaler vio_chk u_chk (.*);

//--- bench/vio_pix_src.sv
// vio_pix_src: pixel source, one 16-bit YCbCr pixel per i_go pulse.
// assumes: i_new_line pulses before the first pixel of a line.
`timescale 1ns/1ps
module vio_pix_src (
  input  wire logic        i_core_clk, i_go, i_new_line, // clock, requests
  input  wire logic [28:0] i_px,  // selector, levels, y, cb, cr
  output logic      [28:0] o_px,  // selector, levels, lanes
  output logic             o_pix_valid, o_line_start // strobes
);
  logic ph;
  initial {o_px, o_pix_valid, o_line_start, ph} = '0;
  always @(posedge i_core_clk) begin
    o_pix_valid <= i_go;
    o_line_start <= i_new_line;
    ph <= !i_new_line && (ph ^ i_go);
    // cb on even pixels, cr on odd; idle lines toggle
    o_px <= i_go ? {i_px[28:24], 8'h00, i_px[23:16],
      ph ? i_px[7:0] : i_px[15:8]} : ~o_px;
  end
endmodule

//--- design/vio_blend.sv
// vio_blend: weighted sum of two YCbCr colours in eighths.
// assumes: weight is 0..8, the share of i_a.
`timescale 1ns/1ps
module vio_blend (
  input  wire logic [23:0] i_a,      // colour weighted by i_weight
  input  wire logic [23:0] i_b,      // colour weighted by 8 - i_weight
  input  wire logic [3:0]  i_weight, // eighths of i_a
  output logic      [23:0] o_mix     // blended colour
);
  import vio_pkg::*;

  // ----------------------------------------------------------------------
  // one weighted sum per component
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_comp
      wire [11:0] part_a = 12'(i_a[gi*8 +: 8]) * 12'(i_weight);
      wire [11:0] part_b = 12'(i_b[gi*8 +: 8]) * 12'(W_FULL - i_weight);
      wire [11:0] sum    = part_a + part_b + 12'h004;
      assign o_mix[gi*8 +: 8] = sum[10:3];
    end
  endgenerate

endmodule

//--- design/vio_input_overlay_upscaler.sv
// vio_input_overlay_upscaler: pixel input, colour conversion, overlay
// mixing and optional 2x upscaling of a video encoder.
// assumes: pixel source synchronous to i_core_clk; APB master for control.
`timescale 1ns/1ps
module vio_input_overlay_upscaler (
  input  wire logic        i_core_clk,         // core clock, 200 MHz
  input  wire logic        i_rstn,             // async reset, active low
  input  wire logic        i_psel,             // APB select
  input  wire logic        i_penable,          // APB enable
  input  wire logic        i_pwrite,           // APB write
  input  wire logic [11:0] i_paddr,            // APB byte address
  input  wire logic [31:0] i_pwdata,           // APB write data
  output logic      [31:0] o_prdata,           // APB read data
  output logic             o_pready,           // APB ready
  output logic             o_pslverr,          // APB error
  input  wire logic [23:0] i_pix,              // pixel input lanes
  input  wire logic        i_pix_valid,        // pixel lanes valid
  input  wire logic [2:0]  i_overlay_hue_pick, // overlay colour code
  input  wire logic        i_blend_level_low,  // mix level, low bit
  input  wire logic        i_blend_level_high, // mix level, high bit
  input  wire logic        i_line_start,       // start of line pulse
  input  wire logic        i_frame_start,      // start of frame pulse
  output logic      [7:0]  o_y,                // luma out
  output logic      [7:0]  o_cb,               // blue difference out
  output logic      [7:0]  o_cr,               // red difference out
  output logic             o_valid,            // output pixel strobe
  output logic             o_field,            // scan field, 1 = 2nd
  output logic             o_line_active       // line in active region
);
  import vio_pkg::*;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] vio_gamma(input logic [7:0] x,
                                           input logic       sel);
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic [11:0] step;
    lo   = sel ? GAMMA28[x[7:4]] : GAMMA22[x[7:4]];
    hi   = sel ? GAMMA28[5'(x[7:4]) + 5'h01] : GAMMA22[5'(x[7:4]) + 5'h01];
    step = 12'(hi - lo) * 12'(x[3:0]);
    return lo + step[11:4];
  endfunction

  function automatic logic [7:0] vio_sat(input int v);
    return (v < 0) ? 8'h00 : (v > 255) ? 8'hFF : 8'(v);
  endfunction

  function automatic logic [7:0] vio_avg(input logic [7:0] a,
                                         input logic [7:0] b);
    logic [8:0] s;
    s = 9'(a) + 9'(b) + 9'h001;
    return s[8:1];
  endfunction

  // ----------------------------------------------------------------------
  // control and status registers
  // ----------------------------------------------------------------------
  logic [31:0] ctrl;
  logic [10:0] hl;
  logic [8:0]  wr_cnt;

  wire vio_fmt_type fmt = vio_fmt_type'(ctrl[CTRL_FMT_LSB +: 2]);
  wire vio_mix_type mix = vio_mix_type'(ctrl[CTRL_MIX_LSB +: 2]);
  wire gamma_sel = ctrl[CTRL_GAMMA_BIT];
  wire linear    = ctrl[CTRL_LINEAR_BIT];
  wire upscale   = ctrl[CTRL_UPSCALE_BIT];
  wire pal       = ctrl[CTRL_PAL_BIT];
  wire is_rgb    = (fmt == FMT_RGB16) || (fmt == FMT_RGB24);

  // scan position, counted in half lines from frame start
  wire [10:0] field_half  = pal ? PAL_FIELD_HALF : NTSC_FIELD_HALF;
  wire [10:0] frame_half  = pal ? PAL_FRAME_HALF : NTSC_FRAME_HALF;
  wire [9:0]  active_cnt  = pal ? PAL_ACTIVE : NTSC_ACTIVE;
  wire        field_now   = hl >= field_half;
  wire [10:0] hl_field    = field_now ? hl - field_half : hl;
  wire [9:0]  lif         = hl_field[10:1];
  wire        active_now  = lif < active_cnt;
  wire        replay_line = upscale & lif[0];
  wire [10:0] hl_step     = hl + 11'd2;
  wire [10:0] next_hl     = (hl_step >= frame_half) ?
                            hl_step - frame_half : hl_step;

  wire [31:0] stat_word = ({23'h0, wr_cnt} << STAT_CNT_LSB)
                        | ({22'h0, lif} << STAT_LINE_LSB)
                        | ({31'h0, replay_line} << STAT_REPLAY_BIT)
                        | ({31'h0, active_now} << STAT_ACTIVE_BIT)
                        | ({31'h0, field_now} << STAT_FIELD_BIT);

  // ----------------------------------------------------------------------
  // APB slave, one wait state
  // ----------------------------------------------------------------------
  wire        acc      = i_psel & i_penable & ~o_pready;
  wire        done     = i_psel & i_penable & o_pready;
  wire        hit_ctrl = i_paddr == CTRL_ADDR;
  wire        hit_stat = i_paddr == STATUS_ADDR;
  wire        mapped   = hit_ctrl | hit_stat;
  wire [31:0] rd_word  = hit_ctrl ? ctrl : hit_stat ? stat_word : 32'h0;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= acc;
      o_pslverr <= acc & ~mapped;
      if (acc) begin
        o_prdata <= i_pwrite ? 32'h0 : rd_word;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl <= CTRL_RESET;
    end else if (done & i_pwrite & hit_ctrl) begin
      ctrl <= i_pwdata & CTRL_MASK;
    end
  end

  // ----------------------------------------------------------------------
  // input capture and format decode
  // ----------------------------------------------------------------------
  logic       bphase;
  logic [7:0] chold;
  logic       cph;

  // in byte-serial mode a pixel is complete on its luma byte
  wire take = i_pix_valid & ((fmt != FMT_YC8) | bphase);

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bphase <= 1'b0;
      chold  <= 8'h00;
      cph    <= 1'b1;
    end else if (i_line_start) begin
      bphase <= 1'b0;
      cph    <= 1'b1;
    end else begin
      if (i_pix_valid & (fmt == FMT_YC8)) begin
        bphase <= ~bphase;
        if (!bphase) begin
          chold <= i_pix[15:8];
        end
      end
      if (take) begin
        cph <= ~cph;
      end
    end
  end

  wire [7:0] in_y = i_pix[15:8];
  wire [7:0] in_c = (fmt == FMT_YC8) ? chold : i_pix[7:0];

  wire [7:0] lin_r = (fmt == FMT_RGB24) ? i_pix[23:16]
                                         : {i_pix[15:11], 3'h0};
  wire [7:0] lin_g = (fmt == FMT_RGB24) ? i_pix[15:8]
                                         : {i_pix[10:5], 2'h0};
  wire [7:0] lin_b = (fmt == FMT_RGB24) ? i_pix[7:0]
                                         : {i_pix[4:0], 3'h0};

  wire [7:0] cor_r = linear ? vio_gamma(lin_r, gamma_sel) : lin_r;
  wire [7:0] cor_g = linear ? vio_gamma(lin_g, gamma_sel) : lin_g;
  wire [7:0] cor_b = linear ? vio_gamma(lin_b, gamma_sel) : lin_b;

  wire [7:0] csc_y  = vio_sat(((CY_R * int'(cor_r) + CY_G * int'(cor_g)
                      + CY_B * int'(cor_b) + 128) >>> 8) + Y_OFS);
  wire [7:0] csc_cb = vio_sat(((CB_R * int'(cor_r) + CB_G * int'(cor_g)
                      + CB_B * int'(cor_b) + 128) >>> 8) + C_OFS);
  wire [7:0] csc_cr = vio_sat(((CR_R * int'(cor_r) + CR_G * int'(cor_g)
                      + CR_B * int'(cor_b) + 128) >>> 8) + C_OFS);

  // overlay pins carry colour data in 24-bit RGB; disabled mode drops them
  wire [2:0] in_sel = ((mix == MIX_OFF) || (fmt == FMT_RGB24)) ?
                      3'h0 : i_overlay_hue_pick;
  wire [1:0] in_lvl = {i_blend_level_high, i_blend_level_low};

  wire [ENT_W-1:0] ent0 = is_rgb ?
    {1'b0, in_lvl, in_sel, csc_y, csc_cb, csc_cr} :
    {cph, in_lvl, in_sel, in_y, in_c, 8'h00};

  // ----------------------------------------------------------------------
  // chroma upsampling, two pixels of look-ahead
  // ----------------------------------------------------------------------
  logic [ENT_W-1:0] ent [1:3];

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 1; i <= 3; i++) begin
        ent[i] <= '0;
      end
    end else if (take) begin
      ent[1] <= ent0;
      for (int i = 2; i <= 3; i++) begin
        ent[i] <= ent[i-1];
      end
    end
  end

  wire [7:0] c0 = ent0[ENT_CB_LSB +: 8];
  wire [7:0] c1 = ent[1][ENT_CB_LSB +: 8];
  wire [7:0] c2 = ent[2][ENT_CB_LSB +: 8];
  wire [7:0] c3 = ent[3][ENT_CB_LSB +: 8];

  // Cb-phase pixels own their pair; Cr-phase pixels average neighbours
  wire [7:0] cv_cb = is_rgb ? c2 :
                     ent[2][ENT_PH] ? c2 : vio_avg(c3, c1);
  wire [7:0] cv_cr = is_rgb ? ent[2][ENT_CR_LSB +: 8] :
                     ent[2][ENT_PH] ? c1 : vio_avg(c2, c0);
  wire [ENT_W-1:0] conv = {ent[2][ENT_W-1:ENT_Y_LSB], cv_cb, cv_cr};

  // ----------------------------------------------------------------------
  // overlay mixer
  // ----------------------------------------------------------------------
  logic [ENT_W-1:0] mcur;
  logic [2:0]       prv_sel;
  logic [23:0]      mo;
  logic             mo_valid;

  wire [2:0]  cur_sel = mcur[ENT_SEL_LSB +: 3];
  wire [2:0]  nxt_sel = conv[ENT_SEL_LSB +: 3];
  wire [1:0]  cur_lvl = mcur[ENT_LVL_LSB +: 2];
  wire [23:0] pix     = mcur[23:0];
  wire [23:0] src_cur = (cur_sel == 3'h0) ? pix : VIO_PALETTE[cur_sel];
  wire [23:0] src_nxt = (nxt_sel == 3'h0) ? pix : VIO_PALETTE[nxt_sel];
  wire [23:0] src_prv = (prv_sel == 3'h0) ? pix : VIO_PALETTE[prv_sel];
  wire [23:0] pal_cur = VIO_PALETTE[cur_sel];

  wire [3:0] ext_w = (cur_lvl == 2'h0) ? W_NONE :
                     (cur_lvl == 2'h1) ? W_LOW  :
                     (cur_lvl == 2'h2) ? W_HIGH : W_FULL;

  // internal mode looks one pixel ahead and one behind
  wire int_ahead  = nxt_sel != cur_sel;
  wire int_behind = cur_sel != prv_sel;

  wire [23:0] bl_a = (mix != MIX_INT) ? pal_cur :
                     int_ahead ? src_nxt : src_cur;
  wire [23:0] bl_b = (mix != MIX_INT) ? pix :
                     int_ahead ? src_cur :
                     int_behind ? src_prv : src_cur;
  wire [3:0]  bl_w = (mix == MIX_INT) ?
                       (int_ahead ? W_LOW : int_behind ? W_HIGH : W_FULL) :
                     (mix == MIX_EXT) ?
                       ((cur_sel == 3'h0) ? W_NONE : ext_w) :
                     (mix == MIX_HARD) ?
                       ((cur_sel == 3'h0) ? W_NONE : W_FULL) :
                     W_NONE;
  wire [23:0] bl_out;

  vio_blend u_blend (
    .i_a      (bl_a),
    .i_b      (bl_b),
    .i_weight (bl_w),
    .o_mix    (bl_out)
  );

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mcur     <= '0;
      prv_sel  <= 3'h0;
      mo       <= 24'h0;
      mo_valid <= 1'b0;
    end else begin
      mo_valid <= take;
      if (take) begin
        mo      <= bl_out;
        mcur    <= conv;
        prv_sel <= cur_sel;
      end
    end
  end

  // ----------------------------------------------------------------------
  // scan counters
  // ----------------------------------------------------------------------
  logic line_go;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hl            <= 11'h000;
      line_go       <= 1'b0;
      o_field       <= 1'b0;
      o_line_active <= 1'b0;
    end else begin
      line_go       <= i_line_start;
      o_field       <= field_now;
      o_line_active <= active_now;
      if (i_frame_start) begin
        hl <= 11'h000;
      end else if (i_line_start) begin
        hl <= next_hl;
      end
    end
  end

  // ----------------------------------------------------------------------
  // line store and replay for vertical doubling
  // ----------------------------------------------------------------------
  logic [23:0] line_buf [0:LINE_BUF_DEPTH-1];
  logic [8:0]  rd_ptr;
  logic        replaying;
  logic [4:0]  div_cnt;

  wire tick    = div_cnt == REPLAY_DIV_LAST;
  wire capture = mo_valid & upscale & ~replay_line & ~replaying;
  wire buf_ok  = wr_cnt < 9'(LINE_BUF_DEPTH);

  always_ff @(posedge i_core_clk) begin
    if (capture & buf_ok) begin
      line_buf[wr_cnt] <= mo;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_cnt    <= 9'h000;
      rd_ptr    <= 9'h000;
      replaying <= 1'b0;
      div_cnt   <= 5'h00;
    end else if (line_go) begin
      div_cnt   <= 5'h00;
      rd_ptr    <= 9'h000;
      replaying <= replay_line;
      if (!replay_line) begin
        wr_cnt <= 9'h000;
      end
    end else begin
      div_cnt <= tick ? 5'h00 : div_cnt + 5'h01;
      if (capture & buf_ok) begin
        wr_cnt <= wr_cnt + 9'h001;
      end
      if (replaying & tick) begin
        if (rd_ptr < wr_cnt) begin
          rd_ptr <= rd_ptr + 9'h001;
        end else begin
          replaying <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // horizontal doubling and output
  // ----------------------------------------------------------------------
  logic [23:0] out_pix;
  logic [23:0] hprev;
  logic [23:0] hold;
  logic        pend;
  logic        first;

  // half-rate input leaves a free cycle for the second sample
  wire        s_go  = replaying ? (tick & (rd_ptr < wr_cnt))
                                : capture;
  wire [23:0] s_pix = replaying ? line_buf[rd_ptr] : mo;
  wire [23:0] s_mid = {vio_avg(hprev[23:16], s_pix[23:16]),
                       vio_avg(hprev[15:8], s_pix[15:8]),
                       vio_avg(hprev[7:0], s_pix[7:0])};

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      out_pix <= 24'h0;
      o_valid <= 1'b0;
      hprev   <= 24'h0;
      hold    <= 24'h0;
      pend    <= 1'b0;
      first   <= 1'b1;
    end else if (!upscale) begin
      o_valid <= mo_valid;
      pend    <= 1'b0;
      if (mo_valid) begin
        out_pix <= mo;
      end
    end else if (s_go) begin
      out_pix <= first ? s_pix : s_mid;
      o_valid <= 1'b1;
      pend    <= 1'b1;
      hold    <= s_pix;
      hprev   <= s_pix;
      first   <= 1'b0;
    end else begin
      o_valid <= pend;
      pend    <= 1'b0;
      if (pend) begin
        out_pix <= hold;
      end
      if (line_go) begin
        first <= 1'b1;
      end
    end
  end

  assign o_y  = out_pix[23:16];
  assign o_cb = out_pix[15:8];
  assign o_cr = out_pix[7:0];

endmodule

//--- include/vio_pkg.sv
// vio_pkg: constants, register map and types of the pixel input pipeline.
// assumes: a single 200 MHz core clock; APB register access.
package vio_pkg;

  // ----------------------------------------------------------------------
  // clock and pacing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ          = 200_000_000;
  localparam int SIF_PIX_HZ      = 6_750_000;
  localparam int REPLAY_DIV      = CLK_HZ / SIF_PIX_HZ;
  localparam logic [4:0] REPLAY_DIV_LAST = 5'(REPLAY_DIV - 1);

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] CTRL_ADDR   = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK   = 32'h0000_03F3;
  localparam int CTRL_FMT_LSB     = 0;
  localparam int CTRL_MIX_LSB     = 4;
  localparam int CTRL_GAMMA_BIT   = 6;
  localparam int CTRL_LINEAR_BIT  = 7;
  localparam int CTRL_UPSCALE_BIT = 8;
  localparam int CTRL_PAL_BIT     = 9;
  localparam int STAT_CNT_LSB     = 0;
  localparam int STAT_LINE_LSB    = 16;
  localparam int STAT_REPLAY_BIT  = 28;
  localparam int STAT_ACTIVE_BIT  = 29;
  localparam int STAT_FIELD_BIT   = 30;

  typedef enum logic [1:0] {
    FMT_YC16  = 2'h0,
    FMT_YC8   = 2'h1,
    FMT_RGB16 = 2'h2,
    FMT_RGB24 = 2'h3
  } vio_fmt_type;

  typedef enum logic [1:0] {
    MIX_OFF  = 2'h0,
    MIX_EXT  = 2'h1,
    MIX_INT  = 2'h2,
    MIX_HARD = 2'h3
  } vio_mix_type;

  // ----------------------------------------------------------------------
  // pixel entry layout and blend weights (eighths of overlay)
  // ----------------------------------------------------------------------
  localparam int ENT_W       = 30;
  localparam int ENT_PH      = 29;
  localparam int ENT_LVL_LSB = 27;
  localparam int ENT_SEL_LSB = 24;
  localparam int ENT_Y_LSB   = 16;
  localparam int ENT_CB_LSB  = 8;
  localparam int ENT_CR_LSB  = 0;
  localparam logic [3:0] W_NONE = 4'h0;
  localparam logic [3:0] W_LOW  = 4'h1;
  localparam logic [3:0] W_HIGH = 4'h7;
  localparam logic [3:0] W_FULL = 4'h8;

  // ----------------------------------------------------------------------
  // colour tables
  // ----------------------------------------------------------------------
  localparam logic [23:0] VIO_PALETTE [0:7] = '{
    24'h108080, 24'h23D472, 24'h515AF0, 24'h6ACADE,
    24'h913622, 24'hAAA610, 24'hA22C8E, 24'hEB8080};
  localparam logic [7:0] GAMMA22 [0:16] = '{
    8'h00, 8'h48, 8'h63, 8'h77, 8'h88, 8'h96, 8'hA3, 8'hAF, 8'hBA,
    8'hC4, 8'hCE, 8'hD7, 8'hE0, 8'hE8, 8'hF0, 8'hF8, 8'hFF};
  localparam logic [7:0] GAMMA28 [0:16] = '{
    8'h00, 8'h5F, 8'h79, 8'h8C, 8'h9B, 8'hA8, 8'hB4, 8'hBE, 8'hC7,
    8'hD0, 8'hD8, 8'hDF, 8'hE6, 8'hED, 8'hF3, 8'hF9, 8'hFF};
  localparam int CY_R  = 66;
  localparam int CY_G  = 129;
  localparam int CY_B  = 25;
  localparam int CB_R  = -38;
  localparam int CB_G  = -74;
  localparam int CB_B  = 112;
  localparam int CR_R  = 112;
  localparam int CR_G  = -94;
  localparam int CR_B  = -18;
  localparam int Y_OFS = 16;
  localparam int C_OFS = 128;

  // ----------------------------------------------------------------------
  // scan structure: field and frame sizes in half lines, active region in lines
  // ----------------------------------------------------------------------
  localparam logic [10:0] NTSC_FIELD_HALF = 11'd525;
  localparam logic [10:0] PAL_FIELD_HALF  = 11'd625;
  localparam logic [10:0] NTSC_FRAME_HALF = 11'd1050;
  localparam logic [10:0] PAL_FRAME_HALF  = 11'd1250;
  localparam logic [9:0]  NTSC_ACTIVE     = 10'd240;
  localparam logic [9:0]  PAL_ACTIVE      = 10'd288;
  localparam int LINE_BUF_DEPTH = 384;

endpackage
